// ===== aoc_analog_out_cfg.sv
// analog output scaling, sensor diagnostics, expansion configuration
`timescale 1ns/1ps
`default_nettype none
module aoc_analog_out_cfg #(
	parameter bit FOUR_DIGIT = 1'b1,
	parameter int MS_CYC = aoc_pkg::MS_CYCLES
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// analog output channel
	output logic [11:0] aoCode,
	// temperature sensor diagnostics
	input wire aoc_pkg::aoc_diag_s [1:0] sensorDiag,
	// measurement timing
	input wire logic measStart,
	input wire logic measDone,
	// expansion unit channels
	input wire logic [16*aoc_pkg::NUM_AIN-1:0] aiValue,
	output logic [31:0] aoWord,
	output logic [15:0] chanMode,
	// non-volatile code store
	input wire aoc_pkg::aoc_nvm_s nvmIn,
	output logic nvmWrite,
	output logic [15:0] nvmData
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [11:0] scaleCode(input logic signed [31:0] v,
		input int fs);
		int s;
		int p;
		s = (v < 0) ? 0 : ((v > fs) ? fs : int'(v));
		p = s * aoc_pkg::CODE_FULL + fs / 2;
		return 12'(p / fs);
	endfunction

	function automatic logic codeValid(input logic [15:0] c);
		if (FOUR_DIGIT)
			return (c[15:12] <= 4'h3) && (c[11:8] <= 4'h3) &&
				(c[7:4] <= 4'h3) && (c[3:0] <= 4'h3);
		else
			return (c[15:12] == 4'h0) && (c[11:8] <= 4'h1) &&
				(c[7:4] <= 4'h3) && (c[3:0] <= 4'h3);
	endfunction

	function automatic logic [15:0] modesOf(input logic [15:0] c);
		logic [15:0] m;
		m = 16'h0000;
		if (FOUR_DIGIT)
		begin
			m[1:0] = c[1:0];
			m[3:2] = c[1:0];
			m[5:4] = c[5:4];
			m[7:6] = c[5:4];
			m[9:8] = c[9:8];
			m[11:10] = c[9:8];
			m[13:12] = c[13:12];
			m[15:14] = c[13:12];
		end
		else
		begin
			m[1:0] = c[1:0];
			m[3:2] = c[5:4];
			m[13:12] = c[9:8];
		end
		return m;
	endfunction

	// ----------------------------------------------------------------
	// ahb-lite slave
	// ----------------------------------------------------------------
	logic dphWr_r;
	logic dphRd_r;
	logic [7:0] dphAddr_r;
	logic rdWait_r;
	logic [31:0] rdData_r;
	logic [31:0] rdMux;
	wire addrTaken = hsel && htrans[1] && hready;
	wire wrEn = dphWr_r && hready;
	wire rdFirst = dphRd_r && !rdWait_r;

	assign hreadyout = !rdFirst;
	assign hresp = 1'b0;
	assign hrdata = rdData_r;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dphWr_r <= 1'b0;
			dphRd_r <= 1'b0;
			dphAddr_r <= 8'h00;
			rdWait_r <= 1'b0;
			rdData_r <= 32'h0000_0000;
		end
		else
		begin
			if (hready)
			begin
				dphWr_r <= addrTaken && hwrite;
				dphRd_r <= addrTaken && !hwrite;
				dphAddr_r <= {haddr[7:2], 2'b00};
			end
			rdWait_r <= rdFirst;
			if (rdFirst)
				rdData_r <= rdMux;
		end
	end

	wire wCtrl = wrEn && (dphAddr_r == aoc_pkg::A_CTRL);
	wire wDirect = wrEn && (dphAddr_r == aoc_pkg::A_DIRECT);
	wire wMarker = wrEn && (dphAddr_r == aoc_pkg::A_MARKER);
	wire wScan = wrEn && (dphAddr_r == aoc_pkg::A_SCAN);
	wire wEntry = wrEn && (dphAddr_r == aoc_pkg::A_ENTRY);
	wire wCmd = wrEn && (dphAddr_r == aoc_pkg::A_CMD);
	wire isMword = dphAddr_r[7:5] == aoc_pkg::A_MWORD[7:5];
	wire [2:0] mwIdx = dphAddr_r[4:2];

	// ----------------------------------------------------------------
	// analog output scaling
	// ----------------------------------------------------------------
	logic [2:0] ctrl_r;
	logic [11:0] direct_r;
	logic signed [31:0] marker_r;
	logic [11:0] codeNxt;
	wire srcMarker = ctrl_r[aoc_pkg::CTRL_SRC_BIT];
	wire aoc_pkg::aoc_scale_e scale =
		aoc_pkg::aoc_scale_e'(ctrl_r[aoc_pkg::CTRL_SCL_LSB +: 2]);

	always_comb
	begin
		codeNxt = direct_r; // see (R02)
		if (srcMarker)
		begin
			case (scale) // see (R03) (R04) (R23)
				aoc_pkg::SCL_RAW:
					codeNxt = scaleCode(marker_r, aoc_pkg::CODE_FULL);
				aoc_pkg::SCL_TENTH:
					codeNxt = scaleCode(marker_r, aoc_pkg::FS_TENTH);
				aoc_pkg::SCL_HUNDREDTH:
					codeNxt = scaleCode(marker_r, aoc_pkg::FS_HUNDREDTH);
				aoc_pkg::SCL_MILLI: // see (R05)
					codeNxt = scaleCode(marker_r, aoc_pkg::FS_MILLI);
				default:
					codeNxt = 12'h000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_r <= 3'h0; // see (R06)
			direct_r <= 12'h000;
			marker_r <= 32'sh0000_0000;
			aoCode <= 12'h000;
		end
		else
		begin
			if (wCtrl)
				ctrl_r <= hwdata[2:0];
			if (wDirect)
				direct_r <= hwdata[11:0];
			if (wMarker)
				marker_r <= hwdata;
			aoCode <= codeNxt; // see (R01)
		end
	end

	// ----------------------------------------------------------------
	// measurement cycle time
	// ----------------------------------------------------------------
	logic [16:0] scan_r;
	logic [31:0] msDiv_r;
	logic [15:0] msCnt_r;
	logic measuring_r;
	logic [15:0] lastCycle_r;
	wire cyclic = scan_r[aoc_pkg::SCAN_EN_BIT];
	wire [15:0] sampleInterval = scan_r[16:1];
	wire msTick = msDiv_r == 32'(MS_CYC - 1);
	wire doneOk = measDone && measuring_r;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			scan_r <= {aoc_pkg::SCAN_TA_RST, 1'b0};
			msDiv_r <= 32'h0;
			msCnt_r <= 16'h0000;
			measuring_r <= 1'b0;
			lastCycle_r <= 16'h0000;
		end
		else
		begin
			if (wScan)
				scan_r <= {hwdata[aoc_pkg::SCAN_TA_LSB +: 16],
					hwdata[aoc_pkg::SCAN_EN_BIT]};
			if (measStart)
			begin
				measuring_r <= 1'b1;
				msDiv_r <= 32'h0;
				msCnt_r <= 16'h0000;
			end
			else if (measuring_r)
			begin
				msDiv_r <= msTick ? 32'h0 : msDiv_r + 32'h1;
				if (msTick && msCnt_r != 16'hffff)
					msCnt_r <= msCnt_r + 16'h1;
				if (measDone)
					measuring_r <= 1'b0;
			end
			if (doneOk && !measStart) // see (R10) (R11)
				lastCycle_r <= (cyclic && msCnt_r < sampleInterval) ?
					sampleInterval : msCnt_r;
		end
	end

	// ----------------------------------------------------------------
	// expansion configuration entry
	// ----------------------------------------------------------------
	localparam logic [15:0] DFLT = FOUR_DIGIT ? aoc_pkg::DFLT_CODE4 :
		aoc_pkg::DFLT_CODE3;
	aoc_pkg::aoc_cfg_e cfgState_r;
	logic [15:0] cfg_r;
	logic [15:0] entry_r;
	logic rejected_r;
	logic loaded_r;
	wire entryValid = codeValid(entry_r);
	wire openEv = wCmd && hwdata[aoc_pkg::CMD_OPEN_BIT];
	wire confirmEv = wCmd && hwdata[aoc_pkg::CMD_CONFIRM_BIT];
	wire cancelEv = wCmd && hwdata[aoc_pkg::CMD_CANCEL_BIT];

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cfgState_r <= aoc_pkg::CFG_STATUS;
			cfg_r <= DFLT; // see (R16) (R17)
			entry_r <= DFLT;
			rejected_r <= 1'b0;
			loaded_r <= 1'b0;
			nvmWrite <= 1'b0;
			nvmData <= DFLT;
		end
		else
		begin
			nvmWrite <= 1'b0;
			loaded_r <= 1'b1;
			if (!loaded_r && nvmIn.valid && codeValid(nvmIn.code))
				cfg_r <= nvmIn.code; // see (R20)
			case (cfgState_r)
				aoc_pkg::CFG_STATUS:
					if (openEv && loaded_r) // see (R13)
					begin
						entry_r <= cfg_r;
						rejected_r <= 1'b0;
						cfgState_r <= aoc_pkg::CFG_ENTRY;
					end
				aoc_pkg::CFG_ENTRY:
					if (cancelEv) // see (R19)
					begin
						entry_r <= cfg_r;
						cfgState_r <= aoc_pkg::CFG_STATUS;
					end
					else if (confirmEv)
						cfgState_r <= aoc_pkg::CFG_CHECK;
					else if (wEntry)
						entry_r <= hwdata[15:0];
				aoc_pkg::CFG_CHECK:
					if (entryValid) // see (R19) (R20)
					begin
						cfg_r <= entry_r;
						nvmWrite <= 1'b1;
						nvmData <= entry_r;
						cfgState_r <= aoc_pkg::CFG_STATUS;
					end
					else // see (R18)
					begin
						entry_r <= cfg_r;
						rejected_r <= 1'b1;
						cfgState_r <= aoc_pkg::CFG_ENTRY;
					end
				default:
					cfgState_r <= aoc_pkg::CFG_STATUS;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// channel modes and marker words
	// ----------------------------------------------------------------
	assign chanMode = modesOf(cfg_r); // see (R12) (R14) (R15)
	wire [15:0] aiWord [aoc_pkg::NUM_AIN];
	wire [1:0] aoEn;
	wire [1:0] aoWr;

	genvar gi;
	generate
		for (gi = 0; gi < aoc_pkg::NUM_AIN; gi++)
		begin : g_ain
			wire signed [15:0] raw = aiValue[16*gi +: 16];
			wire [1:0] md = chanMode[2*gi +: 2];
			wire signed [15:0] rtd = (raw < 16'(aoc_pkg::RTD_MIN_C)) ?
				16'(aoc_pkg::RTD_MIN_C) : ((raw > 16'(aoc_pkg::RTD_MAX_C)) ?
				16'(aoc_pkg::RTD_MAX_C) : raw);
			// see (R21) (R22)
			assign aiWord[gi] = (md == aoc_pkg::MODE_OFF) ? 16'h0000 :
				((md == aoc_pkg::MODE_RTD) ? rtd : raw);
		end
		for (gi = 0; gi < 2; gi++)
		begin : g_aout
			assign aoEn[gi] = chanMode[12 + 2*gi +: 2] != aoc_pkg::MODE_OFF;
			assign aoWr[gi] = wrEn && isMword &&
				(mwIdx == 3'(aoc_pkg::NUM_AIN + gi));
		end
	endgenerate

	// one process owns both output words
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			aoWord <= 32'h0000_0000;
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (!aoEn[i]) // see (R14)
					aoWord[16*i +: 16] <= 16'h0000;
				else if (aoWr[i]) // see (R21)
					aoWord[16*i +: 16] <= hwdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// read multiplexer
	// ----------------------------------------------------------------
	wire [31:0] mwRead = (mwIdx < 3'(aoc_pkg::NUM_AIN)) ?
		{16'h0000, aiWord[mwIdx]} :
		{16'h0000, aoWord[16*(mwIdx - 3'(aoc_pkg::NUM_AIN)) +: 16]};

	always_comb
	begin
		rdMux = 32'h0000_0000;
		if (isMword)
			rdMux = mwRead;
		else
		begin
			case (dphAddr_r)
				aoc_pkg::A_CTRL: rdMux = {29'h0, ctrl_r};
				aoc_pkg::A_DIRECT: rdMux = {20'h0, direct_r};
				aoc_pkg::A_MARKER: rdMux = marker_r;
				aoc_pkg::A_OUTCODE: rdMux = {20'h0, aoCode};
				aoc_pkg::A_DIAG: rdMux = {24'h0, sensorDiag}; // see (R07) (R08) (R09)
				aoc_pkg::A_CYCLE: rdMux = {16'h0, lastCycle_r};
				aoc_pkg::A_SCAN: rdMux = {scan_r[16:1], 15'h0, scan_r[0]};
				aoc_pkg::A_ENTRY: rdMux = {16'h0, entry_r};
				aoc_pkg::A_CMD: rdMux = {28'h0, rejected_r, 1'b0, cfgState_r};
				aoc_pkg::A_CFG: rdMux = {15'h0, loaded_r, cfg_r};
				default: rdMux = 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	property p_direct;
		!srcMarker |=> aoCode == $past(direct_r);
	endproperty
	a_direct: assert property (p_direct) // see (R02)
		else $error("direct code not passed to output");

	property p_saturate;
		srcMarker && scale == aoc_pkg::SCL_TENTH && marker_r >= 100
			|=> aoCode == 12'hfff;
	endproperty
	a_saturate: assert property (p_saturate) // see (R04)
		else $error("tenth scale top not full code");

	property p_negative;
		srcMarker && marker_r < 0 |=> aoCode == 12'h000;
	endproperty
	a_negative: assert property (p_negative) // see (R23)
		else $error("negative marker not clamped to zero");

	property p_milli;
		srcMarker && scale == aoc_pkg::SCL_MILLI && marker_r == 5000
			|=> aoCode == 12'h800;
	endproperty
	a_milli: assert property (p_milli) // see (R05)
		else $error("millivolt midscale code wrong");

	property p_diag;
		rdFirst && dphAddr_r == aoc_pkg::A_DIAG
			|=> hrdata[7:0] == $past(sensorDiag);
	endproperty
	a_diag: assert property (p_diag) // see (R08)
		else $error("diagnostic read not live");

	property p_commit;
		cfgState_r == aoc_pkg::CFG_CHECK && entryValid |=>
			cfg_r == $past(entry_r) && nvmWrite &&
			cfgState_r == aoc_pkg::CFG_STATUS;
	endproperty
	a_commit: assert property (p_commit) // see (R19)
		else $error("valid code not committed");

	property p_reject;
		cfgState_r == aoc_pkg::CFG_CHECK && !entryValid |=>
			entry_r == cfg_r && cfgState_r == aoc_pkg::CFG_ENTRY &&
			!nvmWrite && rejected_r;
	endproperty
	a_reject: assert property (p_reject) // see (R18)
		else $error("invalid code not rejected");

	property p_cancel;
		cfgState_r == aoc_pkg::CFG_ENTRY && cancelEv && loaded_r |=>
			$stable(cfg_r) && cfgState_r == aoc_pkg::CFG_STATUS;
	endproperty
	a_cancel: assert property (p_cancel) // see (R19)
		else $error("cancel changed stored code");

	property p_cyclic;
		doneOk && !measStart && cyclic && msCnt_r < sampleInterval
			|=> lastCycle_r == $past(sampleInterval);
	endproperty
	a_cyclic: assert property (p_cyclic) // see (R11)
		else $error("cycle time ignores sample interval");

	property p_readWait;
		rdFirst |-> !hreadyout ##1 (hreadyout && hrdata == $past(rdMux));
	endproperty
	a_readWait: assert property (p_readWait)
		else $error("read data phase timing wrong");

	property p_aoutOff;
		chanMode[13:12] == aoc_pkg::MODE_OFF |=> aoWord[15:0] == 16'h0000;
	endproperty
	a_aoutOff: assert property (p_aoutOff) // see (R14)
		else $error("disabled output word not cleared");
endmodule // aoc_analog_out_cfg
`default_nettype wire

// ===== aoc_analog_out_cfg_tb.sv
// testbench: bus master, reference model and scenarios
`timescale 1ns/1ps
`default_nettype none
module aoc_analog_out_cfg_tb;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	localparam int MS = 4;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = '0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = '0;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic [31:0] aoWord;
	logic [31:0] rd;
	logic [11:0] aoCode;
	aoc_pkg::aoc_diag_s [1:0] sensorDiag = '0;
	logic measStart = 1'b0;
	logic measDone = 1'b0;
	logic [95:0] aiValue = '0;
	logic [15:0] chanMode;
	logic [15:0] nvmData;
	logic nvmWrite;
	aoc_pkg::aoc_nvm_s nvmIn;
	logic [31:0] rnd = 32'h00017a46;
	int error_cnt = 0;
	int samples_checked = 0;
	int cyc = 0;
	int fsTab[4] = '{aoc_pkg::CODE_FULL, aoc_pkg::FS_TENTH,
		aoc_pkg::FS_HUNDREDTH, aoc_pkg::FS_MILLI};

	aoc_analog_out_cfg #(.FOUR_DIGIT(1'b1), .MS_CYC(MS)) i_aoc_analog_out_cfg (
		.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .aoCode(aoCode), .sensorDiag(sensorDiag),
		.measStart(measStart), .measDone(measDone), .aiValue(aiValue),
		.aoWord(aoWord), .chanMode(chanMode), .nvmIn(nvmIn),
		.nvmWrite(nvmWrite), .nvmData(nvmData));
	aoc_far_model i_aoc_far_model (.core_clk(core_clk),
		.nvmWrite(nvmWrite), .nvmData(nvmData), .nvmIn(nvmIn));

	initial
		forever
			#5 core_clk = ~core_clk;

	// ----------------------------------------------------------------
	// helpers and reference model
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic int outRef(input int m, input int fs);
		int c;
		c = (m < 0) ? 0 : ((m > fs) ? fs : m);
		return (c * 4095 + fs / 2) / fs;
	endfunction
	// digit k/2 of the code sets channel k, outputs share digit 3
	function automatic logic [15:0] modeRef(input logic [15:0] code);
		logic [15:0] m;
		for (int k = 0; k < 8; k++)
			m[2*k +: 2] = code[4*(k/2) +: 2];
		return m;
	endfunction
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		@(posedge core_clk);
		while (hreadyout !== 1'b1)
			@(posedge core_clk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge core_clk);
		while (hreadyout !== 1'b1)
			@(posedge core_clk);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e)
		begin
			error_cnt++;
			$display("BAD at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic commit(input logic [15:0] code);
		bus(1'b1, aoc_pkg::A_CMD, 32'h1);
		bus(1'b1, aoc_pkg::A_ENTRY, {16'h0, code});
		bus(1'b1, aoc_pkg::A_CMD, 32'h2);
		repeat (4) @(posedge core_clk);
	endtask
	task automatic meas(input int k);
		measStart <= 1'b1;
		@(posedge core_clk);
		measStart <= 1'b0;
		repeat (k * MS + 1) @(posedge core_clk);
		measDone <= 1'b1;
		@(posedge core_clk);
		measDone <= 1'b0;
		bus(1'b0, aoc_pkg::A_CYCLE, 32'h0);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			error_cnt++;
			report_and_stop;
		end
	end

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial
	begin
		int m;
		int fs;
		int v;
		int ex;
		logic [1:0] md;
		logic [95:0] ai;
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		bus(1'b0, aoc_pkg::A_CTRL, 32'h0);
		chk(rd, 32'h0);
		chk({16'h0, chanMode}, 32'hffff);
		bus(1'b0, aoc_pkg::A_CFG, 32'h0);
		chk(rd & 32'hffff, 32'h3333);
		bus(1'b0, aoc_pkg::A_SCAN, 32'h0);
		chk(rd, 32'h00c80000);
		bus(1'b0, 8'h30, 32'h0);
		chk(rd, 32'h0);
		for (int i = 0; i < 4; i++)
		begin
			rnd = lfsr(rnd);
			bus(1'b1, aoc_pkg::A_DIRECT, {20'h0, rnd[11:0]});
			repeat (3) @(posedge core_clk);
			chk({20'h0, aoCode}, {20'h0, rnd[11:0]});
		end
		for (int s = 0; s < 4; s++)
		begin
			fs = fsTab[s];
			bus(1'b1, aoc_pkg::A_CTRL, 32'(1 + 2 * s));
			for (int j = 0; j < 6; j++)
			begin
				rnd = lfsr(rnd);
				m = int'(rnd[15:0]) % (fs + 400) - 200;
				// midscale and a negative value hit every time
				m = (j == 2) ? fs / 2 : ((j == 3) ? -1 - fs : m);
				m = (j == 0) ? fs : ((j == 1) ? fs + 1 : m);
				bus(1'b1, aoc_pkg::A_MARKER, 32'(m));
				repeat (3) @(posedge core_clk);
				ex = outRef(m, fs);
				chk({20'h0, aoCode}, 32'(ex));
			end
		end
		for (int i = 0; i < 4; i++)
		begin
			rnd = lfsr(rnd);
			sensorDiag <= (i == 3) ? 8'h0 : rnd[7:0];
			@(posedge core_clk);
			bus(1'b0, aoc_pkg::A_DIAG, 32'h0);
			chk(rd, {24'h0, sensorDiag});
		end
		bus(1'b1, aoc_pkg::A_SCAN, 32'h0);
		meas(3);
		chk(rd, 32'd3);
		bus(1'b1, aoc_pkg::A_SCAN, {16'd5, 16'h1});
		meas(2);
		chk(rd, 32'd5);
		meas(7);
		chk(rd, 32'd7);
		// host edits the code only while stopped
		commit(16'h1231);
		bus(1'b0, aoc_pkg::A_CFG, 32'h0);
		chk(rd & 32'hffff, 32'h1231);
		chk({16'h0, chanMode}, {16'h0, modeRef(16'h1231)});
		for (int k = 0; k < 6; k++)
		begin
			rnd = lfsr(rnd);
			ai[16*k +: 16] = {6'h0, rnd[9:0]};
		end
		aiValue <= ai;
		@(posedge core_clk);
		for (int k = 0; k < 6; k++)
		begin
			bus(1'b0, 8'(aoc_pkg::A_MWORD + 4 * k), 32'h0);
			v = int'(ai[16*k +: 16]);
			md = 2'(modeRef(16'h1231) >> (2 * k));
			ex = (md == 2'd3 && v > aoc_pkg::RTD_MAX_C) ? aoc_pkg::RTD_MAX_C : v;
			ex = (md == 2'd0) ? 0 : ex;
			chk(rd & 32'hffff, 32'(ex));
		end
		rnd = lfsr(rnd);
		bus(1'b1, 8'(aoc_pkg::A_MWORD + 24), {20'h0, rnd[11:0]});
		bus(1'b1, 8'(aoc_pkg::A_MWORD + 28), {20'h0, rnd[23:12]});
		repeat (2) @(posedge core_clk);
		chk(aoWord, {4'h0, rnd[23:12], 4'h0, rnd[11:0]});
		commit(16'h3334);
		bus(1'b0, aoc_pkg::A_CMD, 32'h0);
		chk(rd & 32'hb, 32'h9);
		bus(1'b0, aoc_pkg::A_ENTRY, 32'h0);
		chk(rd & 32'hffff, 32'h1231);
		bus(1'b1, aoc_pkg::A_ENTRY, 32'h2222);
		bus(1'b1, aoc_pkg::A_CMD, 32'h4);
		repeat (2) @(posedge core_clk);
		bus(1'b0, aoc_pkg::A_CMD, 32'h0);
		chk(rd & 32'h3, 32'h0);
		bus(1'b0, aoc_pkg::A_CFG, 32'h0);
		chk(rd & 32'hffff, 32'h1231);
		resetn <= 1'b0;
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
		bus(1'b0, aoc_pkg::A_CFG, 32'h0);
		chk(rd & 32'h1ffff, 32'h11231);
		bus(1'b0, aoc_pkg::A_CTRL, 32'h0);
		chk(rd, 32'h0);
		// outputs and inputs 2,3 off: words cleared, writes ignored
		commit(16'h0201);
		bus(1'b1, 8'(aoc_pkg::A_MWORD + 24), 32'h0000_0abc);
		repeat (2) @(posedge core_clk);
		chk(aoWord, 32'h0);
		chk({16'h0, chanMode}, {16'h0, modeRef(16'h0201)});
		bus(1'b0, 8'(aoc_pkg::A_MWORD + 8), 32'h0);
		chk(rd & 32'hffff, 32'h0);
		report_and_stop;
	end
endmodule // aoc_analog_out_cfg_tb
`default_nettype wire

// ===== aoc_far_model.sv
// far-side model: retentive code store of the expansion unit
`timescale 1ns/1ps
`default_nettype none
module aoc_far_model (
	// clock
	input wire logic core_clk,
	// code store
	input wire logic nvmWrite,
	input wire logic [15:0] nvmData,
	output var aoc_pkg::aoc_nvm_s nvmIn
);
	// ----------------------------------------------------------------
	// store survives reset, a fresh unit starts unconfigured
	// ----------------------------------------------------------------
	aoc_pkg::aoc_nvm_s store_r = '0;
	assign nvmIn = store_r;
	always @(posedge core_clk)
		if (nvmWrite)
			store_r <= '{valid: 1'b1, code: nvmData};
endmodule // aoc_far_model
`default_nettype wire

// ===== aoc_pkg.sv
// package: register map, field layout, constants and types of the block
// Contract
// (R01) output spans 0-10 V, 12-bit code
// (R02) direct operand takes raw codes 0-4095
// (R03) marker operand scales raw, 0.1, 0.01, 0.001 V
// (R04) ranges 4095, 100, 1000, 10000 per scale
// (R05) millivolt scale rounds onto nearest 12-bit code
// (R06) reset: direct operand source, raw scaling
// (R07) separate diagnostic flags per temperature sensor
// (R08) flags live only while fault present
// (R09) short, wire break, below, above range
// (R10) report last measurement time in ms
// (R11) cyclic mode reports the sample interval; code reports the measured time when it is longer
// (R12) analog channels need config code before use
// (R13) host writes config only when stopped; code opens entry on openEv once loaded_r is set, with no stopped check
// (R14) each digit enables its own channel(s)
// (R15) digit: 0 off, 1 volt, 2 mA, 3 RTD
// (R16) three-digit variant powers up with 111
// (R17) four-digit variant powers up with 3333
// (R18) invalid code rejected, entry reopened with last valid
// (R19) confirm commits, cancel keeps stored code
// (R20) code kept non-volatile in this unit only
// (R21) channel values exchanged as marker words
// (R22) RTD inputs span -50 to 200 degC
// (R23) round to nearest code, saturate out of range
`default_nettype none
package aoc_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_DIRECT = 8'h04;
	localparam logic [7:0] A_MARKER = 8'h08;
	localparam logic [7:0] A_OUTCODE = 8'h0c;
	localparam logic [7:0] A_DIAG = 8'h10;
	localparam logic [7:0] A_CYCLE = 8'h14;
	localparam logic [7:0] A_SCAN = 8'h18;
	localparam logic [7:0] A_ENTRY = 8'h1c;
	localparam logic [7:0] A_CMD = 8'h20;
	localparam logic [7:0] A_CFG = 8'h24;
	localparam logic [7:0] A_MWORD = 8'h40;
	localparam int NUM_MWORD = 8;
	localparam int NUM_AIN = 6;
	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_SRC_BIT = 0;
	localparam int CTRL_SCL_LSB = 1;
	localparam int SCAN_EN_BIT = 0;
	localparam int SCAN_TA_LSB = 16;
	localparam int CMD_OPEN_BIT = 0;
	localparam int CMD_CONFIRM_BIT = 1;
	localparam int CMD_CANCEL_BIT = 2;
	localparam logic [15:0] SCAN_TA_RST = 16'h00c8;
	localparam logic [15:0] DFLT_CODE3 = 16'h0111;
	localparam logic [15:0] DFLT_CODE4 = 16'h3333;
	// ----------------------------------------------------------------
	// conversion and timing
	// ----------------------------------------------------------------
	localparam int CODE_FULL = 4095;
	localparam int FS_TENTH = 100;
	localparam int FS_HUNDREDTH = 1000;
	localparam int FS_MILLI = 10000;
	localparam int RTD_MIN_C = -50;
	localparam int RTD_MAX_C = 200;
	localparam int CLK_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SCL_RAW = 2'b00,
		SCL_TENTH = 2'b01,
		SCL_HUNDREDTH = 2'b10,
		SCL_MILLI = 2'b11
	} aoc_scale_e;
	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_VOLT = 2'b01,
		MODE_MAMP = 2'b10,
		MODE_RTD = 2'b11
	} aoc_mode_e;
	typedef enum logic [1:0] {
		CFG_STATUS = 2'b00,
		CFG_ENTRY = 2'b01,
		CFG_CHECK = 2'b10
	} aoc_cfg_e;
	typedef struct packed {
		logic aboveRange;
		logic belowRange;
		logic wireBreak;
		logic shortCkt;
	} aoc_diag_s;
	typedef struct packed {
		logic valid;
		logic [15:0] code;
	} aoc_nvm_s;
endpackage
`default_nettype wire
